// [tc8_timer.sv]
// tc8_timer: 8-bit timer/counter core with sync-control register
`timescale 1ns/1ps
`default_nettype none
module tc8_timer (
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // processor register access
  input  wire tc8_pkg::tc8_io_req_t io_req,
  output logic [7:0]               io_rdata,
  // power reduction and oscillator pin
  input  wire logic                timer_power_gate,
  input  wire logic                osc_pin_one,
  // interrupt requests and service acknowledges
  input  wire logic [2:0]          irq_ack,
  output logic [2:0]               irq_req,
  // waveform generator signals
  output logic                     compare_a_match,
  output logic                     compare_b_match,
  output logic                     cnt_top,
  output logic                     cnt_bottom,
  // shared prescaler taps for the other timers
  output logic [3:0]               shared_taps
);

  ////////////////////////////////////////////////////////////////////////
  // register state
  logic [7:0] counter_value, compare_a_value, compare_b_value;
  logic [7:0] timer_control_a, timer_control_b;
  logic [2:0] timer_flag_register, timer_mask_register;
  logic       async_clock_select, sync_hold_mode;
  logic       shared_prescaler_reset, async_prescaler_reset;
  logic       dir_down, match_block;
  logic [7:0] next_counter_value, next_compare_a_value, next_compare_b_value;
  logic [7:0] next_timer_control_a, next_timer_control_b;
  logic [2:0] next_timer_flag_register, next_timer_mask_register;
  logic       next_async_clock_select, next_sync_hold_mode;
  logic       next_shared_prescaler_reset, next_async_prescaler_reset;
  logic       next_dir_down, next_match_block;
  logic [7:0] next_io_rdata;
  logic [3:0] next_shared_taps;

  // decoded access
  logic       io_hit, wr, rd;
  logic [7:0] addr_full;
  logic [7:0] wdata;

  // timing
  logic                      osc_s1, osc_s2, osc_s3, osc_rise, src_pulse;
  logic [tc8_pkg::PRE_W-1:0] apre, spre;
  logic [2:0]                clock_select_field, wave_mode;
  logic [7:0]                top_val;
  logic                      tap, tick;
  logic                      match_a, match_b;
  logic [2:0]                flag_set, flag_clr;
  logic                      cnt_wr;

  ////////////////////////////////////////////////////////////////////////
  // address decode: short i/o reaches only the 64 locations starting at IO_BASE
  always_comb begin
    io_hit    = 1'b1;
    addr_full = io_req.addr;
    if (io_req.short_io) begin
      io_hit    = (io_req.addr < tc8_pkg::IO_WINDOW);
      addr_full = 8'(io_req.addr + tc8_pkg::IO_BASE);
    end
  end

  assign wr     = io_req.wr && io_hit;
  assign rd     = io_req.rd && io_hit;
  assign wdata  = io_req.wdata;
  assign cnt_wr = wr && (addr_full == tc8_pkg::OFS_COUNT);

  ////////////////////////////////////////////////////////////////////////
  // oscillator pin synchroniser; the second and third stages feed the edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      osc_s1 <= 1'b0;
      osc_s2 <= 1'b0;
      osc_s3 <= 1'b0;
    end else begin
      osc_s1 <= osc_pin_one;
      osc_s2 <= osc_s1;
      osc_s3 <= osc_s2;
    end
  end

  assign osc_rise  = osc_s2 && !osc_s3;
  // source into this timer's prescaler
  assign src_pulse = async_clock_select ? osc_rise : 1'b1;

  tc8_prescaler #(.W(tc8_pkg::PRE_W)) u_async_pre (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (async_prescaler_reset),
    .en      (src_pulse),
    .count   (apre)
  );

  // shared prescaler also clocks the other timers through shared_taps
  tc8_prescaler #(.W(tc8_pkg::PRE_W)) u_shared_pre (
    .clk     (clk),
    .sys_rst (sys_rst),
    .clr     (shared_prescaler_reset),
    .en      (1'b1),
    .count   (spre)
  );

  ////////////////////////////////////////////////////////////////////////
  // tick selection; a held async prescaler reset halts the counter
  assign clock_select_field = timer_control_b[2:0];
  assign wave_mode = {timer_control_b[tc8_pkg::WAVE_BIT2_POS],
                      timer_control_a[1:0]};

  always_comb begin
    case (clock_select_field)
      tc8_pkg::CS_STOP:   tap = 1'b0;
      tc8_pkg::CS_DIRECT: tap = src_pulse;
      tc8_pkg::CS_DIV8:   tap = ((apre & tc8_pkg::MASK_DIV8) == tc8_pkg::MASK_DIV8);
      tc8_pkg::CS_DIV32:  tap = ((apre & tc8_pkg::MASK_DIV32) == tc8_pkg::MASK_DIV32);
      tc8_pkg::CS_DIV64:  tap = ((apre & tc8_pkg::MASK_DIV64) == tc8_pkg::MASK_DIV64);
      tc8_pkg::CS_DIV128: tap = ((apre & tc8_pkg::MASK_DIV128) == tc8_pkg::MASK_DIV128);
      tc8_pkg::CS_DIV256: tap = ((apre & tc8_pkg::MASK_DIV256) == tc8_pkg::MASK_DIV256);
      default:            tap = (apre == tc8_pkg::MASK_DIV1024);
    endcase
  end

  // prescaler taps only count while the source pulses
  assign tick = tap && src_pulse && timer_power_gate
                && !async_prescaler_reset;

  // top is fixed max or compare A depending on mode
  assign top_val = (wave_mode == tc8_pkg::WM_CTC || wave_mode == tc8_pkg::WM_PC_CMP ||
                    wave_mode == tc8_pkg::WM_FAST_CMP) ? compare_a_value
                                                       : tc8_pkg::CNT_MAX;

  // comparators run every cycle, full 8-bit width
  assign match_a = (counter_value == compare_a_value);
  assign match_b = (counter_value == compare_b_value);

  ////////////////////////////////////////////////////////////////////////
  // next state: counter, registers and flags
  always_comb begin
    next_counter_value     = counter_value;
    next_dir_down          = dir_down;
    next_match_block       = match_block;
    next_compare_a_value   = compare_a_value;
    next_compare_b_value   = compare_b_value;
    next_timer_control_a   = timer_control_a;
    next_timer_control_b   = timer_control_b;
    next_timer_mask_register = timer_mask_register;
    next_async_clock_select = async_clock_select;
    next_sync_hold_mode    = sync_hold_mode;
    next_shared_prescaler_reset = shared_prescaler_reset;
    next_async_prescaler_reset  = async_prescaler_reset;
    flag_set = 3'h0;
    flag_clr = irq_ack;
    // counting on each tick
    if (tick) begin
      next_match_block = 1'b0;
      flag_set[tc8_pkg::FLAG_CMP_A] = match_a && !match_block;
      flag_set[tc8_pkg::FLAG_CMP_B] = match_b && !match_block;
      case (wave_mode)
        tc8_pkg::WM_CTC, tc8_pkg::WM_FAST_MAX, tc8_pkg::WM_FAST_CMP: begin
          next_counter_value = (counter_value == top_val) ? tc8_pkg::CNT_BOTTOM
                               : 8'(counter_value + 8'h01);
          flag_set[tc8_pkg::FLAG_OVF] = (wave_mode == tc8_pkg::WM_CTC)
                                        ? (counter_value == tc8_pkg::CNT_MAX)
                                        : (counter_value == top_val);
        end
        tc8_pkg::WM_PC_MAX, tc8_pkg::WM_PC_CMP: begin
          // dual slope; overflow when bottom is reached going down
          if (!dir_down) begin
            if (counter_value == top_val) begin
              next_dir_down      = 1'b1;
              next_counter_value = 8'(counter_value - 8'h01);
            end else begin
              next_counter_value = 8'(counter_value + 8'h01);
            end
          end else if (counter_value == tc8_pkg::CNT_BOTTOM) begin
            next_dir_down      = 1'b0;
            next_counter_value = 8'(counter_value + 8'h01);
          end else begin
            next_counter_value = 8'(counter_value - 8'h01);
            flag_set[tc8_pkg::FLAG_OVF] = (next_counter_value == tc8_pkg::CNT_BOTTOM);
          end
        end
        default: begin
          // normal and reserved codes: plain up count with wrap
          next_counter_value = 8'(counter_value + 8'h01);
          flag_set[tc8_pkg::FLAG_OVF] = (counter_value == tc8_pkg::CNT_MAX);
        end
      endcase
    end
    // hardware clears the reset bits unless held
    if (!sync_hold_mode) begin
      next_shared_prescaler_reset = 1'b0;
      next_async_prescaler_reset  = 1'b0;
    end
    // processor writes; a counter write wins over counting
    if (wr) begin
      case (addr_full)
        tc8_pkg::OFS_SYNC_CTRL: begin
          next_sync_hold_mode         = wdata[tc8_pkg::SYNC_HOLD_BIT];
          next_shared_prescaler_reset = wdata[tc8_pkg::SHARED_PSR_BIT];
          next_async_prescaler_reset  = wdata[tc8_pkg::ASYNC_PSR_BIT];
        end
        tc8_pkg::OFS_COUNT: begin
          next_counter_value = wdata;
          next_match_block   = 1'b1;
        end
        tc8_pkg::OFS_CMP_A:      next_compare_a_value = wdata;
        tc8_pkg::OFS_CMP_B:      next_compare_b_value = wdata;
        tc8_pkg::OFS_CTRL_A:     next_timer_control_a = {6'h00, wdata[1:0]};
        tc8_pkg::OFS_CTRL_B:     next_timer_control_b = {4'h0, wdata[3:0]};
        tc8_pkg::OFS_MASK:       next_timer_mask_register = wdata[2:0];
        tc8_pkg::OFS_ASYNC_STAT: next_async_clock_select = wdata[tc8_pkg::ASYNC_SEL_BIT];
        tc8_pkg::OFS_FLAG:       flag_clr = flag_clr | wdata[2:0];
        default: ;
      endcase
    end
    // a set arriving with its clear is kept
    next_timer_flag_register = (timer_flag_register & ~flag_clr) | flag_set;
  end

  // read mux; reads have no side effects
  always_comb begin
    next_io_rdata = 8'h00;
    if (rd) begin
      case (addr_full)
        tc8_pkg::OFS_SYNC_CTRL: next_io_rdata = {sync_hold_mode, 5'h00,
                                  async_prescaler_reset, shared_prescaler_reset};
        tc8_pkg::OFS_COUNT:      next_io_rdata = counter_value;
        tc8_pkg::OFS_CMP_A:      next_io_rdata = compare_a_value;
        tc8_pkg::OFS_CMP_B:      next_io_rdata = compare_b_value;
        tc8_pkg::OFS_CTRL_A:     next_io_rdata = timer_control_a;
        tc8_pkg::OFS_CTRL_B:     next_io_rdata = timer_control_b;
        tc8_pkg::OFS_FLAG:       next_io_rdata = {5'h00, timer_flag_register};
        tc8_pkg::OFS_MASK:       next_io_rdata = {5'h00, timer_mask_register};
        tc8_pkg::OFS_ASYNC_STAT: next_io_rdata = {2'h0, async_clock_select, 5'h00};
        default:                 next_io_rdata = 8'h00;
      endcase
    end
  end

  // shared taps are quiet while their prescaler is held in reset
  always_comb begin
    next_shared_taps = 4'h0;
    if (!shared_prescaler_reset) begin
      next_shared_taps = {spre == tc8_pkg::MASK_DIV1024,
                          (spre & tc8_pkg::MASK_DIV256) == tc8_pkg::MASK_DIV256,
                          (spre & tc8_pkg::MASK_DIV64) == tc8_pkg::MASK_DIV64,
                          (spre & tc8_pkg::MASK_DIV8) == tc8_pkg::MASK_DIV8};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state and output registers
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      counter_value          <= tc8_pkg::RST_REG;
      compare_a_value        <= tc8_pkg::RST_REG;
      compare_b_value        <= tc8_pkg::RST_REG;
      timer_control_a        <= tc8_pkg::RST_REG;
      timer_control_b        <= tc8_pkg::RST_REG;
      timer_flag_register    <= 3'h0;
      timer_mask_register    <= 3'h0;
      async_clock_select     <= 1'b0;
      sync_hold_mode         <= 1'b0;
      shared_prescaler_reset <= 1'b0;
      async_prescaler_reset  <= 1'b0;
      dir_down               <= 1'b0;
      match_block            <= 1'b0;
      io_rdata               <= 8'h00;
      irq_req                <= 3'h0;
      compare_a_match        <= 1'b0;
      compare_b_match        <= 1'b0;
      cnt_top                <= 1'b0;
      cnt_bottom             <= 1'b0;
      shared_taps            <= 4'h0;
    end else begin
      counter_value          <= next_counter_value;
      compare_a_value        <= next_compare_a_value;
      compare_b_value        <= next_compare_b_value;
      timer_control_a        <= next_timer_control_a;
      timer_control_b        <= next_timer_control_b;
      timer_flag_register    <= next_timer_flag_register;
      timer_mask_register    <= next_timer_mask_register;
      async_clock_select     <= next_async_clock_select;
      sync_hold_mode         <= next_sync_hold_mode;
      shared_prescaler_reset <= next_shared_prescaler_reset;
      async_prescaler_reset  <= next_async_prescaler_reset;
      dir_down               <= next_dir_down;
      match_block            <= next_match_block;
      io_rdata               <= next_io_rdata;
      irq_req                <= next_timer_flag_register & next_timer_mask_register;
      compare_a_match        <= match_a;
      compare_b_match        <= match_b;
      cnt_top                <= (counter_value == tc8_pkg::CNT_MAX);
      cnt_bottom             <= (counter_value == tc8_pkg::CNT_BOTTOM);
      shared_taps            <= next_shared_taps;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  logic sync_wr;
  assign sync_wr = wr && (addr_full == tc8_pkg::OFS_SYNC_CTRL);

  property p_hold_keeps;
    sync_hold_mode && !sync_wr |=> $stable(shared_prescaler_reset)
                                   && $stable(async_prescaler_reset);
  endproperty
  a_hold_keeps: assert property (p_hold_keeps) else $error("reset bits moved in hold");

  property p_release_clears;
    sync_wr && sync_hold_mode && (wdata == 8'h00)
      |=> !sync_hold_mode && !shared_prescaler_reset && !async_prescaler_reset;
  endproperty
  a_release_clears: assert property (p_release_clears) else $error("release kept resets");

  property p_self_clear;
    sync_wr && (wdata == 8'h01) |=> shared_prescaler_reset ##1 !shared_prescaler_reset;
  endproperty
  a_self_clear: assert property (p_self_clear) else $error("shared reset not pulsed");

  property p_taps_quiet;
    shared_prescaler_reset |=> (shared_taps == 4'h0) ##1 (shared_taps == 4'h0);
  endproperty
  a_taps_quiet: assert property (p_taps_quiet) else $error("tap during reset");

  property p_short_io;
    io_req.wr && io_req.short_io && (io_req.addr == 8'h23)
      |=> sync_hold_mode == $past(io_req.wdata[7]);
  endproperty
  a_short_io: assert property (p_short_io) else $error("short write missed");

  property p_stopped;
    (clock_select_field == tc8_pkg::CS_STOP) && !cnt_wr |=> $stable(counter_value);
  endproperty
  a_stopped: assert property (p_stopped) else $error("counter moved while stopped");

  property p_write_wins;
    cnt_wr |=> counter_value == $past(wdata)
               ##1 cnt_bottom == ($past(counter_value) == 8'h00);
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("counter write lost");

  property p_normal_wrap;
    tick && !wr && (wave_mode == tc8_pkg::WM_NORMAL) && (counter_value == 8'hFF)
      |=> (counter_value == 8'h00) && timer_flag_register[0];
  endproperty
  a_normal_wrap: assert property (p_normal_wrap) else $error("no wrap overflow");

  property p_block;
    tick && match_block && !timer_flag_register[1] |=> !timer_flag_register[1];
  endproperty
  a_block: assert property (p_block) else $error("blocked match set flag");

  property p_flag_clear;
    wr && (addr_full == tc8_pkg::OFS_FLAG) && wdata[0] && !tick |=> !timer_flag_register[0];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("flag not cleared");

  c_overflow: cover property (tick && flag_set[tc8_pkg::FLAG_OVF]);
  c_cmp_a:    cover property (tick && flag_set[tc8_pkg::FLAG_CMP_A]);
  c_release:  cover property (sync_hold_mode ##1 !sync_hold_mode);
  c_pc_turn:  cover property (!dir_down ##1 dir_down);

endmodule : tc8_timer
`default_nettype wire

// [tc8_pkg.sv]
// tc8_pkg: constants and carrier types for the 8-bit timer/counter core
package tc8_pkg;

  // short i/o instruction window
  localparam logic [7:0] IO_BASE      = 8'h20;
  localparam logic [7:0] IO_WINDOW    = 8'h40;

  // data-space offsets
  localparam logic [7:0] OFS_SYNC_CTRL  = 8'h43;
  localparam logic [7:0] OFS_FLAG       = 8'h37;
  localparam logic [7:0] OFS_MASK       = 8'h70;
  localparam logic [7:0] OFS_CTRL_A     = 8'hB0;
  localparam logic [7:0] OFS_CTRL_B     = 8'hB1;
  localparam logic [7:0] OFS_COUNT      = 8'hB2;
  localparam logic [7:0] OFS_CMP_A      = 8'hB3;
  localparam logic [7:0] OFS_CMP_B      = 8'hB4;
  localparam logic [7:0] OFS_ASYNC_STAT = 8'hB6;

  // field positions
  localparam int SYNC_HOLD_BIT  = 7;
  localparam int ASYNC_PSR_BIT  = 1;
  localparam int SHARED_PSR_BIT = 0;
  localparam int FLAG_CMP_B     = 2;
  localparam int FLAG_CMP_A     = 1;
  localparam int FLAG_OVF       = 0;
  localparam int WAVE_BIT2_POS  = 3;
  localparam int ASYNC_SEL_BIT  = 5;

  // reset values
  localparam logic [7:0] RST_REG      = 8'h00;

  // counter extremes
  localparam logic [7:0] CNT_BOTTOM   = 8'h00;
  localparam logic [7:0] CNT_MAX      = 8'hFF;

  // clock select codes
  localparam logic [2:0] CS_STOP      = 3'h0;
  localparam logic [2:0] CS_DIRECT    = 3'h1;
  localparam logic [2:0] CS_DIV8      = 3'h2;
  localparam logic [2:0] CS_DIV32     = 3'h3;
  localparam logic [2:0] CS_DIV64     = 3'h4;
  localparam logic [2:0] CS_DIV128    = 3'h5;
  localparam logic [2:0] CS_DIV256    = 3'h6;

  // prescaler width and tap masks (all ones in the mask = tap fires)
  localparam int         PRE_W        = 10;
  localparam logic [9:0] MASK_DIV8    = 10'h007;
  localparam logic [9:0] MASK_DIV32   = 10'h01F;
  localparam logic [9:0] MASK_DIV64   = 10'h03F;
  localparam logic [9:0] MASK_DIV128  = 10'h07F;
  localparam logic [9:0] MASK_DIV256  = 10'h0FF;
  localparam logic [9:0] MASK_DIV1024 = 10'h3FF;

  // waveform modes
  localparam logic [2:0] WM_NORMAL    = 3'h0;
  localparam logic [2:0] WM_PC_MAX    = 3'h1;
  localparam logic [2:0] WM_CTC       = 3'h2;
  localparam logic [2:0] WM_FAST_MAX  = 3'h3;
  localparam logic [2:0] WM_PC_CMP    = 3'h5;
  localparam logic [2:0] WM_FAST_CMP  = 3'h7;

  // processor register access, one cycle per request
  typedef struct packed {
    logic       rd;
    logic       wr;
    logic       short_io;
    logic [7:0] addr;
    logic [7:0] wdata;
  } tc8_io_req_t;

endpackage : tc8_pkg

// [tc8_prescaler.sv]
// tc8_prescaler: free-running prescaler counter with synchronous clear
`timescale 1ns/1ps
`default_nettype none
module tc8_prescaler #(
  parameter int W = 10
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         sys_rst,
  // control
  input  wire logic         clr,
  input  wire logic         en,
  // state
  output logic [W-1:0]      count
);

  logic [W-1:0] next_count;

  // clear beats advance so a held reset freezes every tap
  always_comb begin
    next_count = count;
    if (clr) begin
      next_count = '0;
    end else if (en) begin
      next_count = W'(count + 1'b1);
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count <= '0;
    end else begin
      count <= next_count;
    end
  end

endmodule : tc8_prescaler
`default_nettype wire

// [tc8_timer_bench.sv]
// tc8_timer_bench: self-checking bench for the 8-bit timer/counter core
`timescale 1ns/1ps
`default_nettype none
module tc8_timer_bench;
  logic                 clk;
  logic                 sys_rst;
  tc8_pkg::tc8_io_req_t io_req;
  logic [7:0]           io_rdata;
  logic                 timer_power_gate;
  logic                 osc_pin_one;
  logic [2:0]           irq_ack;
  logic [2:0]           irq_req;
  logic [7:0]           exp_q[$];
  logic [7:0]           exp_v;
  logic [7:0]           v;
  logic                 rd_seen = 1'b0;
  int                   errors;
  int                   tests_run;
  int                   cycles = 0;
  logic                 compare_a_match;
  logic                 compare_b_match;
  logic                 cnt_top;
  logic                 cnt_bottom;
  logic [3:0]           shared_taps;
  int                   seed;
  int                   n;

  tc8_timer u_dut (
    .clk(clk), .sys_rst(sys_rst), .io_req(io_req), .io_rdata(io_rdata),
    .timer_power_gate(timer_power_gate), .osc_pin_one(osc_pin_one),
    .irq_ack(irq_ack), .irq_req(irq_req), .compare_a_match(compare_a_match),
    .compare_b_match(compare_b_match), .cnt_top(cnt_top), .cnt_bottom(cnt_bottom),
    .shared_taps(shared_taps)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // verdict and mismatch reporting
  task automatic summarize();
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic bad(input string msg);
    errors++;
    $display("BAD %0t %s", $time, msg);
  endtask : bad

  // one-cycle request; idle cycle after it so no signal is set twice at once
  task automatic io(input logic r, input logic w, input logic s, input logic [7:0] a,
                    input logic [7:0] d);
    @(posedge clk);
    #1;
    io_req = '{rd: r, wr: w, short_io: s, addr: a, wdata: d};
    @(posedge clk);
    #1;
    io_req = '0;
  endtask : io

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic s = 1'b0);
    io(1'b0, 1'b1, s, a, d);
  endtask : wr

  // expected answer is queued before the request goes out
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic s = 1'b0);
    exp_q.push_back(e);
    io(1'b1, 1'b0, s, a, 8'h00);
  endtask : rd

  // bounded wait; irq_req is sampled after the edge has settled
  task automatic wait_irq(input int b);
    n = 0;
    while (irq_req[b] !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    tests_run++;
    if (irq_req[b] !== 1'b1) bad("interrupt request missing");
  endtask : wait_irq

  ////////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // read checker: answer stands the cycle after the request edge; also timeout
  always @(posedge clk) begin
    if (rd_seen) begin
      exp_v = exp_q.pop_front();
      tests_run++;
      if (io_rdata !== exp_v) bad($sformatf("read %h expected %h", io_rdata, exp_v));
    end
    rd_seen <= io_req.rd;
    cycles++;
    if (cycles > 3000) begin
      bad("timeout");
      summarize();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    seed = 32'hac34;
    errors = 0;
    tests_run = 0;
    io_req = '0;
    irq_ack = 3'h0;
    timer_power_gate = 1'b1;
    osc_pin_one = 1'b0;
    sys_rst = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    rd(tc8_pkg::OFS_SYNC_CTRL, 8'h00);
    rd(tc8_pkg::OFS_COUNT, 8'h00);
    rd(tc8_pkg::OFS_CMP_A, 8'h00);
    rd(tc8_pkg::OFS_CMP_B, 8'h00);
    rd(tc8_pkg::OFS_CTRL_B, 8'h00);
    // counter and both compares are zero here, so bottom and both matches stand
    tests_run++;
    if ({cnt_bottom, cnt_top, compare_a_match, compare_b_match} !== 4'hB) begin
      bad("outputs after reset");
    end
    rd(8'h50, 8'h00);
    rd(8'h43, 8'h00, 1'b1);
    wr(8'h23, 8'h81, 1'b1);
    rd(tc8_pkg::OFS_SYNC_CTRL, 8'h81);
    wr(tc8_pkg::OFS_SYNC_CTRL, 8'h00);
    rd(8'h23, 8'h00, 1'b1);
    wr(tc8_pkg::OFS_SYNC_CTRL, 8'h01);
    // the /8 tap restarts from zero after a shared reset
    @(posedge clk);
    #1;
    n = 0;
    while (shared_taps[0] !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    tests_run++;
    if (n != 8) bad("shared prescaler phase");
    rd(tc8_pkg::OFS_SYNC_CTRL, 8'h00);
    // random counter values survive a stopped clock select
    repeat (4) begin
      v = 8'($random(seed));
      wr(tc8_pkg::OFS_COUNT, v);
      repeat (5) @(posedge clk);
      tests_run++;
      if (cnt_top !== (v == 8'hFF)) bad("top indication");
      if (cnt_bottom !== (v == 8'h00)) bad("bottom indication");
      if (compare_b_match !== (v == 8'h00)) bad("compare b match");
      rd(tc8_pkg::OFS_COUNT, v);
    end
    // random values seldom hit the maximum, so force it once
    wr(tc8_pkg::OFS_COUNT, 8'hFF);
    @(posedge clk);
    #1;
    tests_run++;
    if (cnt_top !== 1'b1) bad("top indication at maximum");
    wr(tc8_pkg::OFS_CMP_A, 8'h80);
    wr(tc8_pkg::OFS_CMP_B, 8'h90);
    wr(tc8_pkg::OFS_MASK, 8'h03);
    // power gate low holds the count even with a source selected
    timer_power_gate = 1'b0;
    wr(tc8_pkg::OFS_COUNT, 8'h33);
    wr(tc8_pkg::OFS_CTRL_B, 8'h01);
    repeat (5) @(posedge clk);
    rd(tc8_pkg::OFS_COUNT, 8'h33);
    wr(tc8_pkg::OFS_CTRL_B, 8'h00);
    timer_power_gate = 1'b1;
    wr(tc8_pkg::OFS_COUNT, 8'hFE);
    wr(tc8_pkg::OFS_CTRL_B, 8'h01);
    wait_irq(0);
    wr(tc8_pkg::OFS_CTRL_B, 8'h00);
    rd(tc8_pkg::OFS_FLAG, 8'h01);
    wr(tc8_pkg::OFS_FLAG, 8'h01);
    rd(tc8_pkg::OFS_FLAG, 8'h00);
    wr(tc8_pkg::OFS_COUNT, 8'h7D);
    wr(tc8_pkg::OFS_CTRL_B, 8'h01);
    wait_irq(1);
    wr(tc8_pkg::OFS_CTRL_B, 8'h00);
    rd(tc8_pkg::OFS_FLAG, 8'h02);
    // service acknowledge clears the compare flag
    @(posedge clk);
    #1;
    irq_ack = 3'h2;
    @(posedge clk);
    #1;
    irq_ack = 3'h0;
    rd(tc8_pkg::OFS_FLAG, 8'h00);
    // a counter write equal to compare A must not raise the flag on the next tick
    wr(tc8_pkg::OFS_COUNT, 8'h80);
    wr(tc8_pkg::OFS_CTRL_B, 8'h01);
    wr(tc8_pkg::OFS_CTRL_B, 8'h00);
    rd(tc8_pkg::OFS_FLAG, 8'h00);
    // clear on compare: two ticks from 2 with top 3 end at zero, flag A one tick late
    wr(tc8_pkg::OFS_CMP_A, 8'h03);
    wr(tc8_pkg::OFS_CTRL_A, 8'h02);
    wr(tc8_pkg::OFS_COUNT, 8'h02);
    wr(tc8_pkg::OFS_CTRL_B, 8'h01);
    wr(tc8_pkg::OFS_CTRL_B, 8'h00);
    rd(tc8_pkg::OFS_COUNT, 8'h00);
    rd(tc8_pkg::OFS_FLAG, 8'h02);
    wr(tc8_pkg::OFS_FLAG, 8'h07);
    wr(tc8_pkg::OFS_CTRL_A, 8'h00);
    // three oscillator rising edges give three ticks
    wr(tc8_pkg::OFS_ASYNC_STAT, 8'h20);
    wr(tc8_pkg::OFS_COUNT, 8'h10);
    wr(tc8_pkg::OFS_CTRL_B, 8'h01);
    repeat (6) begin
      repeat (3) @(posedge clk);
      #1;
      osc_pin_one = ~osc_pin_one;
    end
    repeat (4) @(posedge clk);
    wr(tc8_pkg::OFS_CTRL_B, 8'h00);
    rd(tc8_pkg::OFS_COUNT, 8'h13);
    repeat (3) @(posedge clk);
    summarize();
  end
endmodule : tc8_timer_bench
`default_nettype wire
